// ---- logic/fpc_core.sv ----
// Power-mode and page-size command interpreter of the serial flash
`timescale 1ns/1ps

// Operation
// [RULE_01] Opcode B9h then chip select release enters deep sleep; extra bytes ignored.
// [RULE_02] Ready flag, status byte two bit 7: zero while busy, one when ready.
// [RULE_03] In deep sleep only the resume opcode is decoded; all else ignored.
// [RULE_04] Opcode ABh then release leaves deep sleep within the resume exit time.
// [RULE_05] A resume opcode cut short leaves the device in deep sleep.
// [RULE_06] Entering ultra sleep discards the buffer; it is undefined afterwards.
// [RULE_07] In ultra sleep every opcode, status read and resume included, is ignored.
// [RULE_08] Opcode 79h then release enters ultra sleep within the entry time.
// [RULE_09] A short ultra sleep opcode is dropped; device stays in standby.
// [RULE_10] After power-up the device starts in standby, never asleep.
// [RULE_11] Ultra sleep opcode is ignored while a self-timed program or erase runs.
// [RULE_12] A chip select pulse of the minimum wake time leaves ultra sleep.
// [RULE_13] Standby follows within the exit time; frames before then are ignored.
// [RULE_14] Host waits for the exit time before issuing normal commands.
// [RULE_15] Bytes 3Dh 2Ah 80h A6h select 256-byte buffer and page size.
// [RULE_16] Bytes 3Dh 2Ah 80h A7h select 264-byte buffer and page size.
// [RULE_17] Release after a size command starts a timed write; flag reads busy.
// [RULE_18] Page size is kept across power cycles and applies at once, both ways.
// [RULE_19] The factory page size is 264 bytes.
// [RULE_20] Host should not switch page size more than ten thousand times.
// [RULE_21] A short or mismatched size command leaves the page size unchanged.
module fpc_core #(
  parameter int ULTRA_EXIT_CYC = fpc_pkg::ULTRA_EXIT_CYC,
  parameter int CFG_PROG_CYC   = fpc_pkg::CFG_PROG_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        sck,
  input  wire logic        cs_b,
  input  wire logic        si_data,
  input  wire logic        array_busy,
  input  wire logic        nv_page_256,
  output logic [7:0]       status_byte2,
  output logic             page_256,
  output logic             deep_sleep,
  output logic             ultra_sleep,
  output logic             buf_discard,
  output logic             nv_wr_en,
  output logic             nv_wr_data
);

  // Timer loads are one less than the count, since the load cycle counts too
  localparam logic [23:0] RESUME_LD = 24'(fpc_pkg::RESUME_EXIT_CYC - 1);
  localparam logic [23:0] DEEP_LD   = 24'(fpc_pkg::DEEP_ENTRY_CYC - 1);
  localparam logic [23:0] UENTER_LD = 24'(fpc_pkg::ULTRA_ENTRY_CYC - 1);
  localparam logic [23:0] UEXIT_LD  = 24'(ULTRA_EXIT_CYC - 1);
  localparam logic [23:0] PROG_LD   = 24'(CFG_PROG_CYC - 1);
  localparam logic [7:0]  WAKE_MIN  = 8'(fpc_pkg::WAKE_MIN_CYC);

  // All state of the core in one record: one comb fill, one register
  typedef struct packed {
    fpc_pkg::fpc_mode_t mode;
    logic [23:0] tmr;
    logic        cs1;
    logic        cs2;
    logic        cs3;
    logic        cs4;
    logic [46:0] lk1;
    logic [46:0] lk2;
    logic        par_seen;
    logic [7:0]  low_cnt;
    logic        nv1;
    logic        nv2;
    logic        pend_256;
    logic        page_256;
    logic        ready;
    logic        deep;
    logic        ultra;
    logic        buf_clr;
    logic        nv_we;
    logic        nv_wd;
  } fpc_core_t;

  fpc_core_t  s_q;
  fpc_core_t  s_d;
  logic [5:0] lk_cnt;
  logic [7:0] lk_op;
  logic [31:0] lk_word;
  logic       lk_par;
  logic       f_start;
  logic       f_end;
  logic [5:0] f_bits;
  logic [7:0] f_op;
  logic [31:0] f_word;
  logic       has_op;
  logic       is_cfg;

  // ----------------------------------------------------------------------
  // Link side
  // ----------------------------------------------------------------------
  fpc_link_rx u_rx (
    .sck     (sck),
    .rst_b   (rst_b),
    .cs_b    (cs_b),
    .si_data (si_data),
    .lk_cnt  (lk_cnt),
    .lk_op   (lk_op),
    .lk_word (lk_word),
    .lk_par  (lk_par)
  );

  // Opcode fully shifted in before release
  function automatic logic full_op(input logic [5:0] bits);
    full_op = bits >= fpc_pkg::BITS_OPCODE;
  endfunction

  // ----------------------------------------------------------------------
  // Frame decode
  // ----------------------------------------------------------------------
  // The link words are static once chip select is high, since the serial
  // clock stops; the end is taken one stage after the synchronised release
  // so the two-stage copy of the words is already settled.
  always_comb begin
    f_start = s_q.cs3 & ~s_q.cs2;
    f_end   = s_q.cs3 & ~s_q.cs4;
    f_op    = s_q.lk2[39:32];
    f_word  = s_q.lk2[31:0];
    // A frame with no clock edges leaves the parity unchanged: zero bits
    f_bits  = (s_q.lk2[46] != s_q.par_seen) ? s_q.lk2[45:40] : 6'h00;
    has_op  = full_op(f_bits);
    is_cfg  = (f_bits >= fpc_pkg::BITS_CFG_CMD)                                       // [RULE_21]
              && (f_word[31:8] == fpc_pkg::CFG_PREFIX)
              && ((f_word[7:0] == fpc_pkg::CFG_SIZE_256) || (f_word[7:0] == fpc_pkg::CFG_SIZE_264));
  end

  // ----------------------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    s_d         = s_q;
    s_d.cs1     = cs_b;
    s_d.cs2     = s_q.cs1;
    s_d.cs3     = s_q.cs2;
    s_d.cs4     = s_q.cs3;
    s_d.lk1     = {lk_par, lk_cnt, lk_op, lk_word};
    s_d.lk2     = s_q.lk1;
    s_d.nv1     = nv_page_256;
    s_d.nv2     = s_q.nv1;
    s_d.buf_clr = 1'b0;
    s_d.nv_we   = 1'b0;
    if (f_end) begin
      s_d.par_seen = s_q.lk2[46];
    end
    // Length of the current low pulse, measured on the core clock
    if (f_start) begin
      s_d.low_cnt = 8'h01;
    end else if (!s_q.cs2 && s_q.low_cnt != 8'hff) begin
      s_d.low_cnt = s_q.low_cnt + 8'h01;
    end
    if (s_q.tmr != 24'h000000) begin
      s_d.tmr = s_q.tmr - 24'h000001;
    end
    case (s_q.mode)
      fpc_pkg::FPC_BOOT: begin
        // Stored page size is picked up once the strap has settled
        if (s_q.tmr == 24'h000000) begin
          s_d.mode     = fpc_pkg::FPC_STBY;                                          // [RULE_10]
          s_d.page_256 = s_q.nv2;                                                    // [RULE_18]
        end
      end
      fpc_pkg::FPC_STBY: begin
        // Partial opcodes fall through and leave standby untouched
        if (f_end && has_op && !array_busy && f_op == fpc_pkg::OP_DEEP_SLEEP) begin
          s_d.mode = fpc_pkg::FPC_DEEP_ENTER;                                        // [RULE_01]
          s_d.tmr  = DEEP_LD;
        end else if (f_end && has_op && !array_busy && f_op == fpc_pkg::OP_ULTRA_SLEEP) begin
          s_d.mode    = fpc_pkg::FPC_ULTRA_ENTER;                                    // [RULE_08] [RULE_09] [RULE_11]
          s_d.tmr     = UENTER_LD;
          s_d.buf_clr = 1'b1;                                                        // [RULE_06]
        end else if (f_end && is_cfg && !array_busy) begin
          s_d.mode     = fpc_pkg::FPC_CFG_PROG;                                      // [RULE_17]
          s_d.tmr      = PROG_LD;
          s_d.pend_256 = (f_word[7:0] == fpc_pkg::CFG_SIZE_256);                     // [RULE_15] [RULE_16]
          s_d.nv_we    = 1'b1;
          s_d.nv_wd    = (f_word[7:0] == fpc_pkg::CFG_SIZE_256);
        end
      end
      fpc_pkg::FPC_DEEP_ENTER: begin
        if (s_q.tmr == 24'h000000) begin
          s_d.mode = fpc_pkg::FPC_DEEP;
        end
      end
      fpc_pkg::FPC_DEEP: begin
        // Only a complete resume opcode is heard here
        if (f_end && has_op && f_op == fpc_pkg::OP_RESUME) begin
          s_d.mode = fpc_pkg::FPC_DEEP_EXIT;                                         // [RULE_03] [RULE_04] [RULE_05]
          s_d.tmr  = RESUME_LD;
        end
      end
      fpc_pkg::FPC_DEEP_EXIT: begin
        if (s_q.tmr == 24'h000000) begin
          s_d.mode = fpc_pkg::FPC_STBY;                                              // [RULE_04]
        end
      end
      fpc_pkg::FPC_ULTRA_ENTER: begin
        if (s_q.tmr == 24'h000000) begin
          s_d.mode = fpc_pkg::FPC_ULTRA;
        end
      end
      fpc_pkg::FPC_ULTRA: begin
        // Any bits in the pulse are a dummy byte; only the pulse length counts
        if (f_end && s_q.low_cnt >= WAKE_MIN) begin
          s_d.mode = fpc_pkg::FPC_ULTRA_EXIT;                                        // [RULE_07] [RULE_12]
          s_d.tmr  = UEXIT_LD;
        end
      end
      fpc_pkg::FPC_ULTRA_EXIT: begin
        // Frames in this window are dropped without effect
        if (s_q.tmr == 24'h000000) begin
          s_d.mode = fpc_pkg::FPC_STBY;                                              // [RULE_13]
        end
      end
      fpc_pkg::FPC_CFG_PROG: begin
        // New size applies as soon as the cell is written, no power cycle
        if (s_q.tmr == 24'h000000) begin
          s_d.mode     = fpc_pkg::FPC_STBY;
          s_d.page_256 = s_q.pend_256;                                               // [RULE_18]
        end
      end
      default: begin
        s_d.mode = fpc_pkg::FPC_STBY;
      end
    endcase
    // Outputs follow the next mode so they leave straight from flops
    s_d.ready = (s_d.mode != fpc_pkg::FPC_CFG_PROG) && (s_d.mode != fpc_pkg::FPC_BOOT)  // [RULE_02] [RULE_17]
                && !array_busy;
    s_d.deep  = (s_d.mode == fpc_pkg::FPC_DEEP);
    s_d.ultra = (s_d.mode == fpc_pkg::FPC_ULTRA);
  end

  // Factory size until the stored value is loaded out of boot
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q          <= '0;
      s_q.mode     <= fpc_pkg::FPC_BOOT;
      s_q.tmr      <= fpc_pkg::BOOT_CYC;
      s_q.cs1      <= 1'b1;
      s_q.cs2      <= 1'b1;
      s_q.cs3      <= 1'b1;
      s_q.cs4      <= 1'b1;
      s_q.page_256 <= fpc_pkg::FACTORY_PAGE_256;                                     // [RULE_19]
      s_q.pend_256 <= fpc_pkg::FACTORY_PAGE_256;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  always_comb begin
    status_byte2                         = 8'h00;
    status_byte2[fpc_pkg::STAT_READY_BIT] = s_q.ready;                               // [RULE_02]
  end
  assign page_256    = s_q.page_256;
  assign deep_sleep  = s_q.deep;
  assign ultra_sleep = s_q.ultra;
  assign buf_discard = s_q.buf_clr;
  assign nv_wr_en    = s_q.nv_we;
  assign nv_wr_data  = s_q.nv_wd;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Checks sleep while reset is held, so a mid-run reset aborts open attempts
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_prog_shows_busy: assert property (s_q.mode == fpc_pkg::FPC_CFG_PROG // [RULE_17]
    |-> !status_byte2[7])
    else $error("ready flag set during page size write");

  a_boot_to_stby: assert property (s_q.mode == fpc_pkg::FPC_BOOT // [RULE_10]
    |=> s_q.mode inside {fpc_pkg::FPC_BOOT, fpc_pkg::FPC_STBY})
    else $error("boot left to a mode other than standby");

  a_deep_ignores: assert property ((s_q.mode == fpc_pkg::FPC_DEEP // [RULE_03]
    && !(f_end && has_op && f_op == fpc_pkg::OP_RESUME)) |=> s_q.mode == fpc_pkg::FPC_DEEP)
    else $error("deep sleep left without a resume");

  a_resume_timing: assert property ($rose(s_q.mode == fpc_pkg::FPC_DEEP_EXIT) // [RULE_04]
    |-> s_q.tmr == RESUME_LD)
    else $error("resume exit timer loaded wrongly");

  a_ultra_ignores: assert property ((s_q.mode == fpc_pkg::FPC_ULTRA // [RULE_07]
    && !(f_end && s_q.low_cnt >= WAKE_MIN)) |=> s_q.mode == fpc_pkg::FPC_ULTRA)
    else $error("ultra sleep left without a wake pulse");

  a_buf_discard: assert property (buf_discard // [RULE_06]
    |-> s_q.mode == fpc_pkg::FPC_ULTRA_ENTER ##1 !buf_discard)
    else $error("buffer discard outside ultra sleep entry");

  a_busy_blocks: assert property ((s_q.mode == fpc_pkg::FPC_STBY && array_busy) // [RULE_11]
    |=> s_q.mode == fpc_pkg::FPC_STBY)
    else $error("sleep or size command taken while busy");

  a_exit_ignores: assert property ((s_q.mode == fpc_pkg::FPC_ULTRA_EXIT && s_q.tmr != 24'h000000) // [RULE_13]
    |=> s_q.mode == fpc_pkg::FPC_ULTRA_EXIT)
    else $error("ultra sleep exit window cut short");

  a_size_held: assert property ((s_q.mode != fpc_pkg::FPC_BOOT // [RULE_21]
    && !(s_q.mode == fpc_pkg::FPC_CFG_PROG && s_q.tmr == 24'h000000)) |=> $stable(page_256))
    else $error("page size changed without a finished write");

  a_nv_write: assert property (nv_wr_en // [RULE_17]
    |-> s_q.mode == fpc_pkg::FPC_CFG_PROG && s_q.tmr == PROG_LD && nv_wr_data == s_q.pend_256)
    else $error("nonvolatile write not paired with a size command");

  a_deep_entry: assert property ((s_q.mode == fpc_pkg::FPC_DEEP_ENTER && s_q.tmr == 24'h000000) // [RULE_01]
    |=> deep_sleep)
    else $error("deep sleep not reached after the entry time");

  a_resume_abort: assert property ((s_q.mode == fpc_pkg::FPC_DEEP && f_end && !has_op) // [RULE_05]
    |=> deep_sleep)
    else $error("cut resume opcode left deep sleep");

  a_short_ultra: assert property ((s_q.mode == fpc_pkg::FPC_STBY && f_end && !has_op) // [RULE_09]
    |=> s_q.mode == fpc_pkg::FPC_STBY && !buf_discard)
    else $error("cut opcode changed the mode");

  a_ultra_entry: assert property ((s_q.mode == fpc_pkg::FPC_ULTRA_ENTER && s_q.tmr == 24'h000000) // [RULE_08]
    |=> ultra_sleep)
    else $error("ultra sleep not reached after the entry time");

  a_wake_exit: assert property ((s_q.mode == fpc_pkg::FPC_ULTRA && f_end && s_q.low_cnt >= WAKE_MIN) // [RULE_12]
    |=> !ultra_sleep && s_q.tmr == UEXIT_LD)
    else $error("wake pulse did not start the exit window");

  a_ready_busy: assert property (array_busy // [RULE_02]
    |=> !status_byte2[7])
    else $error("ready flag set while the array is busy");

  a_size_apply: assert property ((s_q.mode == fpc_pkg::FPC_CFG_PROG && s_q.tmr == 24'h000000) // [RULE_18]
    |=> page_256 == $past(s_q.pend_256))
    else $error("new page size not applied after the write");

  a_boot_load: assert property ((s_q.mode == fpc_pkg::FPC_BOOT && s_q.tmr == 24'h000000) // [RULE_18]
    |=> page_256 == $past(s_q.nv2))
    else $error("stored page size not loaded out of boot");

endmodule

// ---- logic/fpc_link_rx.sv ----
// Serial-clock side shifter: counts bits and keeps the opcode and first four bytes of a frame
`timescale 1ns/1ps

module fpc_link_rx (
  input  wire logic        sck,
  input  wire logic        rst_b,
  input  wire logic        cs_b,
  input  wire logic        si_data,
  output logic [5:0]       lk_cnt,
  output logic [7:0]       lk_op,
  output logic [31:0]      lk_word,
  output logic             lk_par
);

  typedef struct packed {
    logic [5:0]  cnt;
    logic [7:0]  op;
    logic [31:0] word;
    logic        par;
  } fpc_rx_t;

  fpc_rx_t s_q;
  fpc_rx_t s_d;
  logic    fresh_q;
  logic    idle;

  // ----------------------------------------------------------------------
  // Frame start marker
  // ----------------------------------------------------------------------
  // The serial clock stands still between frames, so the start of a frame is
  // marked by a flag that chip select sets and the first bit edge clears.
  assign idle = cs_b | ~rst_b;

  always_ff @(posedge sck or posedge idle) begin
    if (idle) begin
      fresh_q <= 1'b1;
    end else begin
      fresh_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Shift and count
  // ----------------------------------------------------------------------
  // Bytes past the fourth are not stored; trailing data only raises the count
  always_comb begin
    s_d = s_q;
    if (fresh_q) begin
      s_d.cnt  = 6'h01;
      s_d.op   = 8'h00;
      s_d.word = {31'h00000000, si_data};
      s_d.par  = ~s_q.par;           // Tells the core a frame carried bits
    end else begin
      if (s_q.cnt < fpc_pkg::BITS_CFG_CMD) begin
        s_d.word = {s_q.word[30:0], si_data};
      end
      if (s_q.cnt == fpc_pkg::BITS_OPCODE - 6'h01) begin
        s_d.op = {s_q.word[6:0], si_data};
      end
      if (s_q.cnt != fpc_pkg::BITS_SAT) begin
        s_d.cnt = s_q.cnt + 6'h01;
      end
    end
  end

  // Sampled on the rising edge, as in SPI modes 0 and 3
  always_ff @(posedge sck or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign lk_cnt  = s_q.cnt;
  assign lk_op   = s_q.op;
  assign lk_word = s_q.word;
  assign lk_par  = s_q.par;

endmodule

// ---- logic/fpc_pkg.sv ----
// Constants and types shared by the power-mode and page-size command block
package fpc_pkg;

  // ----------------------------------------------------------------------
  // Opcodes and command bytes
  // ----------------------------------------------------------------------
  localparam logic [7:0]  OP_DEEP_SLEEP  = 8'hb9;
  localparam logic [7:0]  OP_RESUME      = 8'hab;
  localparam logic [7:0]  OP_ULTRA_SLEEP = 8'h79;
  localparam logic [23:0] CFG_PREFIX     = 24'h3d2a80;
  localparam logic [7:0]  CFG_SIZE_256   = 8'ha6;
  localparam logic [7:0]  CFG_SIZE_264   = 8'ha7;

  // ----------------------------------------------------------------------
  // Frame geometry and status layout
  // ----------------------------------------------------------------------
  localparam int          CNT_W          = 6;
  localparam logic [5:0]  BITS_OPCODE    = 6'h08;
  localparam logic [5:0]  BITS_CFG_CMD   = 6'h20;
  localparam logic [5:0]  BITS_SAT       = 6'h3f;
  localparam int          STAT_READY_BIT = 7;
  localparam int          TMR_W          = 24;
  localparam int          LOW_W          = 8;

  // Reset values: shipped page size is 264 bytes (page_256 low)
  localparam logic        FACTORY_PAGE_256 = 1'b0;
  localparam logic [23:0] BOOT_CYC         = 24'h000002;

  // ----------------------------------------------------------------------
  // Timing: figures in ns, counts at the 25 MHz core clock
  // ----------------------------------------------------------------------
  localparam int CLK_NS                  = 40;
  localparam int RESUME_EXIT_TIME_NS     = 35000;
  localparam int DEEP_SLEEP_ENTRY_TIME_NS = 3000;
  localparam int ULTRA_SLEEP_ENTRY_TIME_NS = 3000;
  localparam int ULTRA_SLEEP_EXIT_TIME_NS = 180000;
  localparam int WAKE_PULSE_MIN_TIME_NS  = 20;
  localparam int CONFIG_PROGRAM_TIME_NS  = 50000000;

  // Longest times round down, least times round up; only the entry and resume exit counts are held at one cycle or more
  localparam int RESUME_EXIT_CYC  = (RESUME_EXIT_TIME_NS / CLK_NS < 1) ? 1 : RESUME_EXIT_TIME_NS / CLK_NS;
  localparam int DEEP_ENTRY_CYC   = (DEEP_SLEEP_ENTRY_TIME_NS / CLK_NS < 1) ? 1 : DEEP_SLEEP_ENTRY_TIME_NS / CLK_NS;
  localparam int ULTRA_ENTRY_CYC  = (ULTRA_SLEEP_ENTRY_TIME_NS / CLK_NS < 1) ? 1 : ULTRA_SLEEP_ENTRY_TIME_NS / CLK_NS;
  localparam int ULTRA_EXIT_CYC   = ULTRA_SLEEP_EXIT_TIME_NS / CLK_NS;
  localparam int WAKE_MIN_CYC     = (WAKE_PULSE_MIN_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int CFG_PROG_CYC     = CONFIG_PROGRAM_TIME_NS / CLK_NS;

  // ----------------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    FPC_BOOT,
    FPC_STBY,
    FPC_DEEP_ENTER,
    FPC_DEEP,
    FPC_DEEP_EXIT,
    FPC_ULTRA_ENTER,
    FPC_ULTRA,
    FPC_ULTRA_EXIT,
    FPC_CFG_PROG
  } fpc_mode_t;

endpackage

// ---- sim/fpc_host.sv ----
// Host serial controller model that drives chip select, link clock and data
`timescale 1ns/1ps

module fpc_host (
  output logic cs_b,
  output logic sck,
  output logic si_data
);
  // ----------------------------------------------------------------------
  // Idle link
  // ----------------------------------------------------------------------
  // Deselected, with the link clock parked low between frames
  initial begin
    cs_b    = 1'b1;
    sck     = 1'b0;
    si_data = 1'b0;
  end

  // ----------------------------------------------------------------------
  // Frames
  // ----------------------------------------------------------------------
  // Shifts the top n bits of val, MSB first, 32 ns period, odd phase to the core
  task automatic send(input logic [31:0] val, input int n);
    #7 cs_b = 1'b0;
    for (int i = 0; i < n; i++) begin
      si_data = val[31-i];
      #16 sck = 1'b1;
      #16 sck = 1'b0;
    end
    #16 cs_b = 1'b1;
    si_data = ~si_data;  // Released line must not keep showing the last bit
  endtask

  // Chip select low with a still clock, three core cycles, well above the minimum
  task automatic pulse();
    #7 cs_b = 1'b0;
    #120 cs_b = 1'b1;
  endtask
endmodule

// ---- sim/tb.sv ----
// Self-checking bench for the power-mode and page-size command block
`timescale 1ns/1ps

module tb;
  logic       clk;
  logic       rst_b;
  logic       array_busy;
  logic       nv_page_256 = 1'b0;
  logic       cs_b;
  logic       sck;
  logic       si_data;
  logic [7:0] status_byte2;
  logic       page_256;
  logic       deep_sleep;
  logic       ultra_sleep;
  logic       buf_discard;
  logic       nv_wr_en;
  logic       nv_wr_data;
  int         n_fail;
  int         tests_run;
  int         n_cyc;
  int         n_wr;
  int         n_disc;

  // Short exit and program counts keep the run brief
  fpc_core #(.ULTRA_EXIT_CYC(20), .CFG_PROG_CYC(50)) i_dut (
    .clk(clk), .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .si_data(si_data),
    .array_busy(array_busy), .nv_page_256(nv_page_256), .status_byte2(status_byte2),
    .page_256(page_256), .deep_sleep(deep_sleep), .ultra_sleep(ultra_sleep),
    .buf_discard(buf_discard), .nv_wr_en(nv_wr_en), .nv_wr_data(nv_wr_data));

  fpc_host i_host (.cs_b(cs_b), .sck(sck), .si_data(si_data));

  // ----------------------------------------------------------------------
  // Clock, pulse counters and hang guard
  // ----------------------------------------------------------------------
  initial clk = 1'b0;
  always #20 clk = ~clk;

  // Pulses are one cycle wide, so they are counted rather than sampled
  always @(posedge clk) begin
    n_cyc++;
    if (nv_wr_en === 1'b1) begin
      n_wr++;
      nv_page_256 <= nv_wr_data;  // Stored size cell keeps what was written
    end
    if (buf_discard === 1'b1) n_disc++;
    if (n_cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Reset, boot load of the stored size, then the standby state
  task automatic t_reset(input logic pg);
    cyc(2);
    check({status_byte2, page_256, deep_sleep, ultra_sleep, nv_wr_en}, 32'h0);
    rst_b <= 1'b1;
    cyc(1);
    check(status_byte2[7], 1'b0);
    cyc(6);
    check(status_byte2, 8'h80);
    check(page_256, pg);
    check({deep_sleep, ultra_sleep}, 2'h0);
  endtask

  // Size command: busy during the write, new size applied afterwards
  task automatic t_cfg(input logic [7:0] last, input logic exp);
    int w;
    w = n_wr;
    i_host.send({fpc_pkg::CFG_PREFIX, last}, 32);
    cyc(8);
    check(status_byte2[7], 1'b0);
    check(n_wr - w, 1);
    check(nv_wr_data, exp);
    cyc(60);
    check(status_byte2, 8'h80);
    check(page_256, exp);
  endtask

  // Wrong last byte and a cut-short command leave the size alone
  task automatic t_bad();
    int w;
    w = n_wr;
    i_host.send({fpc_pkg::CFG_PREFIX, 8'ha5}, 32);
    cyc(8);
    i_host.send({fpc_pkg::CFG_PREFIX, fpc_pkg::CFG_SIZE_256}, 24);
    cyc(8);
    check(n_wr - w, 0);
    check(page_256, 1'b0);
  endtask

  // Deep sleep: trailing bytes, ignored commands, short and full resume
  task automatic t_deep();
    int w;
    int d;
    i_host.send({fpc_pkg::OP_DEEP_SLEEP, 24'h0000ff}, 16);
    cyc(90);
    check(deep_sleep, 1'b1);
    w = n_wr;
    d = n_disc;
    i_host.send({fpc_pkg::CFG_PREFIX, fpc_pkg::CFG_SIZE_256}, 32);
    cyc(8);
    i_host.send({fpc_pkg::OP_ULTRA_SLEEP, 24'h0}, 8);
    cyc(90);
    check(n_wr - w, 0);
    check(n_disc - d, 0);
    check({deep_sleep, ultra_sleep}, 2'h2);
    i_host.send({fpc_pkg::OP_RESUME, 24'h0}, 5);
    cyc(10);
    check(deep_sleep, 1'b1);
    i_host.send({fpc_pkg::OP_RESUME, 24'hff0000}, 16);
    cyc(10);
    check(deep_sleep, 1'b0);
    cyc(900);  // Host sits out the resume exit time
  endtask

  // Ultra sleep: short opcode, busy array, entry, wake, early frame
  task automatic t_ultra();
    int d;
    d = n_disc;
    i_host.send({fpc_pkg::OP_ULTRA_SLEEP, 24'h0}, 4);
    cyc(90);
    check(ultra_sleep, 1'b0);
    check(n_disc - d, 0);
    array_busy <= 1'b1;
    cyc(3);
    check(status_byte2[7], 1'b0);
    i_host.send({fpc_pkg::OP_ULTRA_SLEEP, 24'h0}, 8);
    cyc(90);
    check(ultra_sleep, 1'b0);
    array_busy <= 1'b0;
    cyc(3);
    check(status_byte2, 8'h80);
    i_host.send({fpc_pkg::OP_ULTRA_SLEEP, 24'h550000}, 16);
    cyc(8);
    check(n_disc - d, 1);
    cyc(80);
    check(ultra_sleep, 1'b1);
    i_host.send({fpc_pkg::OP_DEEP_SLEEP, 24'h0}, 8);
    cyc(6);
    check(ultra_sleep, 1'b0);
    cyc(90);
    check(deep_sleep, 1'b0);
    i_host.send({fpc_pkg::OP_ULTRA_SLEEP, 24'h0}, 8);
    cyc(90);
    d = n_disc;
    i_host.pulse();
    cyc(6);
    i_host.send({fpc_pkg::OP_ULTRA_SLEEP, 24'h0}, 8);
    cyc(120);
    check(ultra_sleep, 1'b0);
    check(n_disc - d, 0);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence; only two size switches keep wear low
  // ----------------------------------------------------------------------
  initial begin
    rst_b       = 1'b0;
    array_busy  = 1'b0;
    t_reset(1'b0);
    t_cfg(fpc_pkg::CFG_SIZE_256, 1'b1);
    rst_b <= 1'b0;  // Power cycle: the stored 256-byte size must come back
    t_reset(1'b1);
    t_cfg(fpc_pkg::CFG_SIZE_264, 1'b0);
    t_bad();
    t_deep();
    t_ultra();
    end_sim();
  end
endmodule
